// ==== common/serial_port_pkg.sv ====
// Constants for the clocked serial port register block.
// Assumes an Avalon-MM word-addressed slave; address equals register index.
package serial_port_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_MODE_CLOCK  = 16'hffa0;
  localparam logic [15:0] IDX_CTRL_STATUS = 16'hffa1;
  localparam logic [15:0] IDX_DATA_UPPER  = 16'hffa2;
  localparam logic [15:0] IDX_DATA_LOWER  = 16'hffa3;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'hffa4;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'hffa5;

  localparam logic [7:0]  MODE_CLOCK_RST  = 8'h00;

  // Mode/clock register fields
  localparam int MODE_HI_BIT   = 7;
  localparam int MODE_LO_BIT   = 6;
  localparam int TAIL_MARK_BIT = 5;
  localparam int TAIL_LAT_BIT  = 4;
  localparam int CLK_SRC_BIT   = 3;

  // Control/status fields
  localparam int CS_START_BIT  = 0;
  localparam int CS_LEVEL_BIT  = 1;
  localparam int CS_DONE_BIT   = 7;

  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_CONT  = 2'h2;

  localparam logic [4:0] BITS_8  = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;

  // Half periods of the shift clock in system clocks, less one, for divide 1024 .. 2
  localparam logic [8:0] HALF_DIV [8] = '{9'h1ff, 9'h07f, 9'h01f, 9'h00f,
                                          9'h007, 9'h003, 9'h001, 9'h000};

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_FINISH = 2'b11
  } xfer_state_t;

endpackage : serial_port_pkg

// ==== rtl/clocked_serial_port_regs.sv ====
// Clocked synchronous serial port: registers, shift clock and shift engine.
// Assumes an Avalon-MM master on sys_clk; serial pins are asynchronous inputs.
//
// Operation
// - Mode field: 00 eight-bit, 01 sixteen-bit, 10 continuous clock, 11 reserved.
// - Eight-bit mode: lower data register holds the sent and received word.
// - Sixteen-bit mode: lower register holds low byte, upper register high byte.
// - Done flag clears only by writing 0, and writing 1 leaves it unchanged; irq status clears by writing 1.
// - Writing 1 to the output level control bit while idle drives the serial data pin high.
`timescale 1ns/1ps
module clocked_serial_port_regs
  import serial_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq,
  input  wire logic        shiftClockIn,
  output logic             shiftClockOut,
  output logic             shiftClockOe,
  input  wire logic        shiftInPin,
  output logic             shiftOutPin
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  modeClock_r;
  logic [7:0]  dataUpper_r;
  logic [7:0]  dataLower_r;
  logic        doneFlag_r;
  logic        irqStatus_r;
  logic        irqMask_r;
  logic        waitReq_r;
  logic [31:0] readData_r;
  logic        irq_r;
  logic        sckOut_r;
  logic        soOut_r;
  logic        contRun_r;
  logic [8:0]  divCnt_r;
  logic [4:0]  bitCnt_r;
  xfer_state_t state_r;
  logic        sckSync1_r, sckSync2_r, sckSync3_r;
  logic        siSync1_r, siSync2_r;

  wire         accept    = (read | write) & waitReq_r;
  // Writes land at the edge where the master sees waitrequest low
  wire         ack       = (read | write) & ~waitReq_r;
  wire         wrAcc     = write & ack;
  wire         wrMode    = wrAcc & (address == IDX_MODE_CLOCK);
  wire         wrCs      = wrAcc & (address == IDX_CTRL_STATUS);
  wire         wrUpper   = wrAcc & (address == IDX_DATA_UPPER);
  wire         wrLower   = wrAcc & (address == IDX_DATA_LOWER);
  wire         wrIrqSt   = wrAcc & (address == IDX_IRQ_STATUS);
  wire         wrIrqMk   = wrAcc & (address == IDX_IRQ_MASK);
  wire [1:0]   mode      = modeClock_r[MODE_HI_BIT:MODE_LO_BIT];
  wire         extClk    = modeClock_r[CLK_SRC_BIT];
  wire [2:0]   prescSel  = modeClock_r[2:0];
  wire         busy      = (state_r != ST_IDLE) | contRun_r;
  wire         modeIsCont = (mode == MODE_CONT);
  wire         modeOk    = (mode == MODE_8BIT) | (mode == MODE_16BIT);
  wire         startReq  = wrCs & writedata[CS_START_BIT] & ~busy;
  wire         startXfer = startReq & modeOk;
  wire         startCont = startReq & modeIsCont;
  wire         stopCont  = wrCs & ~writedata[CS_START_BIT] & contRun_r;
  wire         levelHigh = wrCs & writedata[CS_LEVEL_BIT] & ~busy;
  wire [4:0]   xferBits  = (mode == MODE_16BIT) ? BITS_16 : BITS_8;
  wire         intRun    = ~extClk & ((state_r == ST_SHIFT) | contRun_r);
  wire         divHit    = intRun & (divCnt_r == HALF_DIV[prescSel]);
  wire         intFall   = divHit & sckOut_r;
  wire         intRise   = divHit & ~sckOut_r;
  wire         extFall   = extClk & sckSync3_r & ~sckSync2_r;
  wire         extRise   = extClk & ~sckSync3_r & sckSync2_r;
  wire         clkFall   = (state_r == ST_SHIFT) & (intFall | extFall);
  wire         clkRise   = (state_r == ST_SHIFT) & (intRise | extRise);
  wire         lastRise  = clkRise & (bitCnt_r == xferBits - 5'h01);
  wire         doneEvent = (state_r == ST_FINISH);
  wire [7:0]   csView    = {doneFlag_r, 5'h00, soOut_r, busy};
  wire [7:0]   rdByte    = (address == IDX_MODE_CLOCK)  ? modeClock_r :
                           (address == IDX_CTRL_STATUS) ? csView :
                           (address == IDX_DATA_UPPER)  ? dataUpper_r :
                           (address == IDX_DATA_LOWER)  ? dataLower_r :
                           (address == IDX_IRQ_STATUS)  ? {7'h00, irqStatus_r} :
                           (address == IDX_IRQ_MASK)    ? {7'h00, irqMask_r} : 8'h00;

  assign readdata      = readData_r;
  assign waitrequest   = waitReq_r;
  assign irq           = irq_r;
  assign shiftClockOut = sckOut_r;
  assign shiftClockOe  = ~extClk;
  assign shiftOutPin   = soOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitReq_r  <= 1'b1;
      readData_r <= 32'h0000_0000;
    end else begin
      waitReq_r  <= ~accept;
      if (read & accept) begin
        readData_r <= {24'h00_0000, rdByte};
      end
    end
  end

  // Mode register is frozen while shifting so a transfer cannot change shape
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeClock_r <= MODE_CLOCK_RST;
    end else if (wrMode & ~busy) begin
      modeClock_r <= writedata[7:0];
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sckSync1_r <= 1'b1;
      sckSync2_r <= 1'b1;
      sckSync3_r <= 1'b1;
      siSync1_r  <= 1'b0;
      siSync2_r  <= 1'b0;
    end else begin
      sckSync1_r <= shiftClockIn;
      sckSync2_r <= sckSync1_r;
      sckSync3_r <= sckSync2_r;
      siSync1_r  <= shiftInPin;
      siSync2_r  <= siSync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and internal shift clock; idles high
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_r <= 9'h000;
      sckOut_r <= 1'b1;
    end else if (~intRun) begin
      divCnt_r <= 9'h000;
      sckOut_r <= 1'b1;
    end else if (divHit) begin
      divCnt_r <= 9'h000;
      sckOut_r <= ~sckOut_r;
    end else begin
      divCnt_r <= divCnt_r + 9'h001;
    end
  end

  // Transfer sequencer; data out on falling edge, sampled on rising edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 5'h00;
      contRun_r <= 1'b0;
    end else begin
      if (startCont) begin
        contRun_r <= 1'b1;
      end else if (stopCont) begin
        contRun_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          bitCnt_r <= 5'h00;
          if (startXfer) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (lastRise) begin
            state_r <= ST_FINISH;
          end else if (clkRise) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        ST_FINISH: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Data registers double as the shift register, low bit first.
  // Reset value is a choice: the pins show zero rather than unknown.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataUpper_r <= 8'h00;
      dataLower_r <= 8'h00;
    end else if (clkRise & (mode == MODE_16BIT)) begin
      {dataUpper_r, dataLower_r} <= {siSync2_r, dataUpper_r, dataLower_r[7:1]};
    end else if (clkRise) begin
      dataLower_r <= {siSync2_r, dataLower_r[7:1]};
    end else if (~busy) begin
      if (wrUpper) begin
        dataUpper_r <= writedata[7:0];
      end
      if (wrLower) begin
        dataLower_r <= writedata[7:0];
      end
    end
  end

  // Serial data pin holds its last bit after a transfer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soOut_r <= 1'b0;
    end else if (levelHigh) begin
      soOut_r <= 1'b1;
    end else if (clkFall) begin
      soOut_r <= dataLower_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: done clears on write 0; sticky irq clears on write 1; set wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneFlag_r  <= 1'b0;
      irqStatus_r <= 1'b0;
      irqMask_r   <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      if (doneEvent) begin
        doneFlag_r <= 1'b1;
      end else if (wrCs & ~writedata[CS_DONE_BIT]) begin
        doneFlag_r <= 1'b0;
      end
      if (doneEvent) begin
        irqStatus_r <= 1'b1;
      end else if (wrIrqSt & writedata[0]) begin
        irqStatus_r <= 1'b0;
      end
      if (wrIrqMk) begin
        irqMask_r <= writedata[0];
      end
      irq_r <= irqStatus_r & irqMask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_csWriteOne;
    wrCs & writedata[CS_DONE_BIT] & ~doneEvent;
  endsequence

  AST_MODE_RESERVED_NO_START: assert property (
    (startReq & (mode == 2'h3)) |=> (state_r == ST_IDLE) && !contRun_r)
    else $error("reserved mode started a transfer");
  AST_LOWER_SHIFT_8: assert property (
    (clkRise && mode == MODE_8BIT) |=> (dataLower_r[7] == $past(siSync2_r))
      && $stable(dataUpper_r))
    else $error("eight-bit shift wrong");
  AST_UPPER_SHIFT_16: assert property (
    (clkRise && mode == MODE_16BIT) |=> (dataUpper_r[7] == $past(siSync2_r))
      && (dataLower_r[7] == $past(dataUpper_r[0])))
    else $error("sixteen-bit shift wrong");
  AST_FLAG_WRITE_ONE_KEEPS: assert property (
    (s_csWriteOne ##0 doneFlag_r) |=> doneFlag_r)
    else $error("done flag cleared by writing one");
  AST_FLAG_SET_WINS: assert property (
    doneEvent |=> doneFlag_r && irqStatus_r)
    else $error("done event lost");
  AST_LEVEL_HIGH: assert property (
    levelHigh |=> shiftOutPin)
    else $error("output level not driven high");
  AST_CLOCK_DIR: assert property (
    shiftClockOe == !modeClock_r[CLK_SRC_BIT])
    else $error("clock pin direction wrong");
  AST_BUS_ANSWER: assert property (
    ((read | write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
  AST_IRQ_LEVEL: assert property (
    (irqStatus_r && irqMask_r) |=> irq)
    else $error("interrupt not raised");

endmodule : clocked_serial_port_regs

// ==== testbench/serial_peer_model.sv ====
// Far-side serial peripheral: shifts a word out LSB first and captures input.
// Assumes a shift clock idling high; data changes on fall, sampled on rise.
`timescale 1ns/1ps
module serial_peer_model (
  input  wire logic        sclk,
  input  wire logic        sdo,
  input  wire logic        arm,
  input  wire logic        extOn,
  input  wire logic [15:0] txWord,
  output logic             sdi,
  output logic             extClk,
  output logic      [15:0] rxWord
);
  int idx = 0;
  initial sdi = 1'b0;
  initial extClk = 1'b1;
  initial rxWord = '0;
  // Runs only within frames, phase free of the system clock
  // Stops high after sixteen bits so no stray edge follows the frame
  always #32 extClk = (extOn && !(extClk && idx >= 16)) ? ~extClk : 1'b1;
  always @(negedge sclk) if (arm) begin
    sdi <= txWord[idx];
    idx <= idx + 1;
  end
  always @(posedge sclk) if (arm) rxWord <= {sdo, rxWord[15:1]};
  // Released line flips so a stale bit cannot pass for data
  always @(negedge arm) begin
    sdi <= ~sdi;
    idx <= 0;
  end
endmodule : serial_peer_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the clocked serial port register block.
// Assumes the peer model on the serial pins and an Avalon master here.
`timescale 1ns/1ps
module tb_top;
  import serial_port_pkg::*;
  logic        sys_clk, sys_rst, read, write, arm, extOn;
  logic [15:0] address, txWord, rxWord;
  logic [31:0] writedata, readdata;
  logic        waitrequest, irq, sckOut, sckOe, sdi, sdo, extClk;
  logic [7:0]  q;
  int          failures, compares;
  wire         sckPin = sckOe ? sckOut : extClk;

  clocked_serial_port_regs u_clocked_serial_port_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .shiftClockIn(sckPin),
    .shiftClockOut(sckOut), .shiftClockOe(sckOe), .shiftInPin(sdi),
    .shiftOutPin(sdo));
  serial_peer_model u_serial_peer_model (
    .sclk(sckPin), .sdo(sdo), .arm(arm), .extOn(extOn), .txWord(txWord),
    .sdi(sdi), .extClk(extClk), .rxWord(rxWord));

  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One access; an idle edge follows so strobes never re-rise in one step
  task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    address <= a;
    writedata <= {24'h0, d};
    write <= we;
    read <= ~we;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) chk("waitrequest", 0, waitrequest);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wait_done();
    int n = 0;
    do begin
      bus(0, IDX_CTRL_STATUS, 0);
      n++;
    end while (q[CS_DONE_BIT] !== 1'b1 && n < 500);
    chk("done", 1, q[CS_DONE_BIT]);
  endtask : wait_done
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(0, IDX_MODE_CLOCK, 0);
    chk("mode rst", MODE_CLOCK_RST, q);
    bus(0, 16'hffa7, 0);
    chk("unmapped", 0, q);
    chk("irq rst", 0, irq);
  endtask : t_reset
  task automatic t_eight();
    bus(1, IDX_IRQ_MASK, 8'h01);
    bus(1, IDX_MODE_CLOCK, 8'h05);
    bus(1, IDX_DATA_LOWER, 8'ha5);
    txWord = 16'h003c;
    arm = 1;
    bus(1, IDX_CTRL_STATUS, 8'h01);
    wait_done();
    arm = 0;
    chk("peer rx8", 8'ha5, rxWord[15:8]);
    bus(0, IDX_DATA_LOWER, 0);
    chk("lower rx8", 8'h3c, q);
    chk("irq set", 1, irq);
    chk("clk idle", 1, sckOut);
    bus(1, IDX_IRQ_STATUS, 8'h01);
    @(posedge sys_clk);
    chk("irq clr", 0, irq);
  endtask : t_eight
  task automatic t_sixteen();
    bus(1, IDX_IRQ_MASK, 8'h00);
    bus(1, IDX_MODE_CLOCK, 8'h48);
    chk("oe ext", 0, sckOe);
    bus(1, IDX_DATA_UPPER, 8'h12);
    bus(1, IDX_DATA_LOWER, 8'h34);
    txWord = 16'hbeef;
    arm = 1;
    bus(1, IDX_CTRL_STATUS, 8'h01);
    extOn = 1;
    wait_done();
    extOn = 0;
    arm = 0;
    chk("peer rx16", 16'h1234, rxWord);
    chk("masked irq", 0, irq);
    bus(0, IDX_DATA_UPPER, 0);
    chk("upper rx16", 8'hbe, q);
    bus(0, IDX_DATA_LOWER, 0);
    chk("lower rx16", 8'hef, q);
  endtask : t_sixteen
  task automatic t_flags();
    bus(1, IDX_CTRL_STATUS, 8'h80);
    bus(0, IDX_CTRL_STATUS, 0);
    chk("done w1", 1, q[CS_DONE_BIT]);
    bus(1, IDX_CTRL_STATUS, 8'h00);
    bus(0, IDX_CTRL_STATUS, 0);
    chk("done w0", 0, q[CS_DONE_BIT]);
    bus(1, IDX_CTRL_STATUS, 8'h02);
    chk("so high", 1, sdo);
  endtask : t_flags
  task automatic t_modes();
    int rises = 0;
    bus(1, IDX_MODE_CLOCK, 8'hc7);
    bus(1, IDX_CTRL_STATUS, 8'h01);
    bus(0, IDX_CTRL_STATUS, 0);
    chk("reserved", 0, q[CS_START_BIT]);
    bus(1, IDX_MODE_CLOCK, 8'h87);
    bus(1, IDX_CTRL_STATUS, 8'h01);
    repeat (20) @(posedge sys_clk) rises += (sckOut === 1'b0);
    chk("cont clk", 1, rises > 5);
    bus(1, IDX_CTRL_STATUS, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("cont stop", 1, sckOut);
  endtask : t_modes
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    {sys_clk, read, write, arm, extOn, failures, compares} = '0;
    {address, writedata, txWord} = '0;
    sys_rst = 1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    t_reset();
    t_eight();
    t_sixteen();
    t_flags();
    t_modes();
    report_and_stop();
  end
endmodule : tb_top
